// ---- hw/mmts_top.v ----
// Contract
// - Timer A counts special clock or phi/8..64
// - Pulse mode toggles pin A at underflow
// - Pulse output starts high if edge 0
// - Event mode counts selected edge of pin A
// - Width mode counts only while level matches
// - Write control A: latch only or both
// - Pin A request on selected edge
// - Timer B is 16-bit, four modes
// - Timer B counts phi/8..64, or pin B edges in event mode
// - Timer B toggles pin in timer mode when output enabled
// - Period mode: edge reloads and requests
// - Capture pre-reload count until low byte is read
// - Period mode: edge 0 falling, 1 rising
// - Timer B event mode counts selected edge
// - HL mode: both edges reload and request
// - Write control B: latch only or both
// - Three 8-bit timers, independent sources
// - Narrow write control for timers 1,2
// - Narrow toggle from timer 1 or 2
// - Underflow reloads, continues, sets request
// - Count stop halts timer A
`include "mmts_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module mmts_top (
   // Clock, reset, enable
   input wire mclk,
   input wire nrst,
   input wire ce,
   // Count sources and pins
   input wire special_count_source_clock,
   input wire event_pin_a,
   input wire event_pin_b,
   // Timer A configuration
   input wire [1:0] mode_a,
   input wire [1:0] div_sel_a,
   input wire use_special_a,
   input wire edge_select_a,
   input wire write_ctrl_a,
   input wire count_stop_a,
   // Timer B configuration
   input wire [1:0] mode_b,
   input wire [1:0] div_sel_b,
   input wire edge_select_b,
   input wire write_ctrl_b,
   input wire out_ctrl_b,
   // Narrow configuration
   input wire [1:0] src_sel_n1,
   input wire [1:0] src_sel_n2,
   input wire [1:0] src_sel_n3,
   input wire narrow_write_ctrl,
   input wire narrow_out_ctrl,
   input wire narrow_factor_sel,
   input wire narrow_edge,
   // Byte access port
   input wire wr_strobe,
   input wire rd_strobe,
   input wire [2:0] acc_sel,
   input wire acc_high,
   input wire [7:0] wr_data,
   output reg [7:0] rd_data_reg,
   // Pin drives
   output reg event_a_out_reg,
   output reg event_a_oe_reg,
   output reg wide_b_toggle_output,
   output reg event_b_oe_reg,
   output reg narrow_toggle_reg,
   // Interrupt request pulses
   output reg irq_a_reg,
   output reg irq_b_reg,
   output reg irq_n1_reg,
   output reg irq_n2_reg,
   output reg irq_n3_reg,
   output reg irq_pin_a_reg,
   output reg irq_pin_b_reg
);
////////////////////////////////////////////////////////////////////////////////
   reg rst_s1_reg;
   reg rst_n_reg;
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_s1_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_n_reg <= rst_s1_reg;
      end
   end
////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; the last stage feeds edge detection
   reg [2:0] sync1_reg;
   reg [2:0] sync2_reg;
   reg [2:0] prev_reg;
   always @(posedge mclk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
         prev_reg <= 3'h0;
      end
      else if (ce)
      begin
         sync1_reg <= {special_count_source_clock, event_pin_b, event_pin_a};
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end
   wire a_lvl = sync2_reg[0];
   wire b_lvl = sync2_reg[1];
   wire a_rise = sync2_reg[0] & ~prev_reg[0];
   wire a_fall = ~sync2_reg[0] & prev_reg[0];
   wire b_rise = sync2_reg[1] & ~prev_reg[1];
   wire b_fall = ~sync2_reg[1] & prev_reg[1];
   wire scs_tick = sync2_reg[2] & ~prev_reg[2];
////////////////////////////////////////////////////////////////////////////////
   // Shared prescaler; a tick is the wrap of the selected bit
   reg [`MMTS_PRESC_W-1:0] presc_reg;
   always @(posedge mclk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
         presc_reg <= 6'h00;
      else if (ce)
         presc_reg <= presc_reg + 6'h01;
   end
   wire div8 = (presc_reg[2:0] == 3'h7);
   wire div16 = (presc_reg[3:0] == 4'hf);
   wire div32 = (presc_reg[4:0] == 5'h1f);
   wire div64 = (presc_reg == 6'h3f);
   function divsel;
      input [1:0] s;
      input d8, d16, d32, d64;
      begin
         case (s)
            `MMTS_DIV8: divsel = d8;
            `MMTS_DIV16: divsel = d16;
            `MMTS_DIV32: divsel = d32;
            default: divsel = d64;
         endcase
      end
   endfunction
////////////////////////////////////////////////////////////////////////////////
   // Write and read decode
   wire wr_a = wr_strobe && (acc_sel == `MMTS_WSEL_A);
   wire wr_b = wr_strobe && (acc_sel == `MMTS_WSEL_B);
   wire [7:0] lo_a;
   wire [7:0] lo_b;
   reg [7:0] lo_a_reg;
   reg [7:0] lo_b_reg;
   // Low byte is staged; the counter is written when the high byte lands
   wire wr_a_full = wr_a && acc_high;
   wire wr_b_full = wr_b && acc_high;
   assign lo_a = lo_a_reg;
   assign lo_b = lo_b_reg;
////////////////////////////////////////////////////////////////////////////////
   // Timer A
   wire [15:0] cnt_a;
   wire [15:0] lat_a;
   wire uf_a;
   reg tick_a;
   always @*
   begin
      tick_a = 1'b0;
      case (mode_a)
         `MMTS_MODE_EVENT: tick_a = edge_select_a ? a_fall : a_rise;
         `MMTS_MODE_WIDTH: tick_a = (use_special_a ? scs_tick
            : divsel(div_sel_a, div8, div16, div32, div64))
            && (a_lvl ^ edge_select_a);
         default: tick_a = use_special_a ? scs_tick
            : divsel(div_sel_a, div8, div16, div32, div64);
      endcase
      if (count_stop_a)
         tick_a = 1'b0;
   end
   mmts_down_counter #(.W(16)) u_wide_a (
      .mclk(mclk), .rst_n(rst_n_reg), .ce(ce),
      .tick(tick_a), .force_reload(1'b0),
      .wr(wr_a_full), .latch_only(write_ctrl_a), .wdata({wr_data, lo_a}),
      .count_reg(cnt_a), .latch_reg(lat_a), .underflow(uf_a)
   );
////////////////////////////////////////////////////////////////////////////////
   // Timer B
   wire [15:0] cnt_b;
   wire [15:0] lat_b;
   wire uf_b;
   wire b_meas = (mode_b == `MMTS_BMODE_PERIOD) || (mode_b == `MMTS_BMODE_HL);
   wire b_edge = (mode_b == `MMTS_BMODE_HL) ? (b_rise | b_fall)
      : (edge_select_b ? b_rise : b_fall);
   wire meas_b = b_meas && b_edge;
   wire tick_b = (mode_b == `MMTS_BMODE_EVENT) ? (edge_select_b ? b_fall : b_rise)
      : divsel(div_sel_b, div8, div16, div32, div64);
   mmts_down_counter #(.W(16)) u_wide_b (
      .mclk(mclk), .rst_n(rst_n_reg), .ce(ce),
      .tick(tick_b), .force_reload(meas_b),
      .wr(wr_b_full), .latch_only(write_ctrl_b), .wdata({wr_data, lo_b}),
      .count_reg(cnt_b), .latch_reg(lat_b), .underflow(uf_b)
   );
////////////////////////////////////////////////////////////////////////////////
   // Narrow timers; source 3 cascades from the previous timer's underflow
   wire [23:0] cnt_n;
   wire [2:0] uf_n;
   wire [2:0] casc = {uf_n[1], uf_n[0], uf_b};
   wire [5:0] src_n = {src_sel_n3, src_sel_n2, src_sel_n1};
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_narrow
         wire [1:0] s = src_n[2*gi+1:2*gi];
         wire t = (s == `MMTS_NSRC_DIV8) ? div8
            : (s == `MMTS_NSRC_DIV16) ? div16
            : (s == `MMTS_NSRC_SCS) ? scs_tick : casc[gi];
         // Timer 3 has no latch-only option
         wire lo = (gi < 2) ? narrow_write_ctrl : 1'b0;
         localparam [31:0] SEL_FULL = `MMTS_WSEL_N1 + gi;
         wire [2:0] sel = SEL_FULL[2:0];
         mmts_down_counter #(.W(8)) u_narrow (
            .mclk(mclk), .rst_n(rst_n_reg), .ce(ce),
            .tick(t), .force_reload(1'b0),
            .wr(wr_strobe && (acc_sel == sel)),
            .latch_only(lo), .wdata(wr_data),
            .count_reg(cnt_n[8*gi+7:8*gi]), .latch_reg(), .underflow(uf_n[gi])
         );
      end
   endgenerate
////////////////////////////////////////////////////////////////////////////////
   // Capture, snapshot, outputs
   reg [15:0] cap_b_reg;
   reg cap_valid_reg;
   reg [7:0] snap_lo_reg;
   reg pulse_a_mode_q;
   reg out_b_q;
   reg nout_q;
   wire pulse_a = (mode_a == `MMTS_MODE_PULSE);
   wire tog_b = (mode_b == `MMTS_BMODE_TIMER) && out_ctrl_b;
   wire [15:0] rd_b = cap_valid_reg ? cap_b_reg : cnt_b;
   wire uf_sel = narrow_factor_sel ? uf_n[1] : uf_n[0];
   always @(posedge mclk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         lo_a_reg <= 8'h00;
         lo_b_reg <= 8'h00;
         cap_b_reg <= 16'h0000;
         cap_valid_reg <= 1'b0;
         snap_lo_reg <= 8'h00;
         rd_data_reg <= 8'h00;
         pulse_a_mode_q <= 1'b0;
         out_b_q <= 1'b0;
         nout_q <= 1'b0;
         event_a_out_reg <= 1'b0;
         event_a_oe_reg <= 1'b0;
         wide_b_toggle_output <= 1'b0;
         event_b_oe_reg <= 1'b0;
         narrow_toggle_reg <= 1'b0;
         irq_a_reg <= 1'b0;
         irq_b_reg <= 1'b0;
         irq_n1_reg <= 1'b0;
         irq_n2_reg <= 1'b0;
         irq_n3_reg <= 1'b0;
         irq_pin_a_reg <= 1'b0;
         irq_pin_b_reg <= 1'b0;
      end
      else if (ce)
      begin
         if (wr_a && !acc_high)
            lo_a_reg <= wr_data;
         if (wr_b && !acc_high)
            lo_b_reg <= wr_data;
         // Capture wins over a read in the same cycle
         if (meas_b)
         begin
            cap_b_reg <= cnt_b;
            cap_valid_reg <= 1'b1;
         end
         else if (rd_strobe && acc_sel == `MMTS_WSEL_B && !acc_high)
            cap_valid_reg <= 1'b0;
         if (rd_strobe)
         begin
            case (acc_sel)
               `MMTS_WSEL_A:
               begin
                  rd_data_reg <= acc_high ? cnt_a[15:8] : snap_lo_reg;
                  if (acc_high)
                     snap_lo_reg <= cnt_a[7:0];
               end
               `MMTS_WSEL_B:
               begin
                  rd_data_reg <= acc_high ? rd_b[15:8] : snap_lo_reg;
                  if (acc_high)
                     snap_lo_reg <= rd_b[7:0];
               end
               `MMTS_WSEL_N1: rd_data_reg <= cnt_n[7:0];
               `MMTS_WSEL_N2: rd_data_reg <= cnt_n[15:8];
               `MMTS_WSEL_N3: rd_data_reg <= cnt_n[23:16];
               default: rd_data_reg <= 8'h00;
            endcase
         end
         // Toggle outputs restart at their start level when enabled
         pulse_a_mode_q <= pulse_a;
         out_b_q <= tog_b;
         nout_q <= narrow_out_ctrl;
         event_a_oe_reg <= pulse_a;
         if (pulse_a && !pulse_a_mode_q)
            event_a_out_reg <= ~edge_select_a;
         else if (pulse_a && uf_a)
            event_a_out_reg <= ~event_a_out_reg;
         event_b_oe_reg <= tog_b;
         if (tog_b && !out_b_q)
            wide_b_toggle_output <= ~edge_select_b;
         else if (tog_b && uf_b)
            wide_b_toggle_output <= ~wide_b_toggle_output;
         if (narrow_out_ctrl && !nout_q)
            narrow_toggle_reg <= ~narrow_edge;
         else if (narrow_out_ctrl && uf_sel)
            narrow_toggle_reg <= ~narrow_toggle_reg;
         irq_a_reg <= uf_a;
         irq_b_reg <= uf_b;
         irq_n1_reg <= uf_n[0];
         irq_n2_reg <= uf_n[1];
         irq_n3_reg <= uf_n[2];
         irq_pin_a_reg <= edge_select_a ? a_fall : a_rise;
         irq_pin_b_reg <= b_meas ? b_edge : (edge_select_b ? b_fall : b_rise);
      end
   end
endmodule // mmts_top
`default_nettype wire

// ---- hw/mmts_defs.vh ----
`ifndef MMTS_DEFS_VH
`define MMTS_DEFS_VH
// Wide timer mode field encodings
`define MMTS_MODE_TIMER 2'h0
`define MMTS_MODE_PULSE 2'h1
`define MMTS_MODE_EVENT 2'h2
`define MMTS_MODE_WIDTH 2'h3
// Wide timer B modes
`define MMTS_BMODE_TIMER 2'h0
`define MMTS_BMODE_PERIOD 2'h1
`define MMTS_BMODE_EVENT 2'h2
`define MMTS_BMODE_HL 2'h3
// Prescaler select: phi/8, /16, /32, /64
`define MMTS_DIV8 2'h0
`define MMTS_DIV16 2'h1
`define MMTS_DIV32 2'h2
`define MMTS_DIV64 2'h3
// Narrow source select
`define MMTS_NSRC_DIV8 2'h0
`define MMTS_NSRC_DIV16 2'h1
`define MMTS_NSRC_SCS 2'h2
`define MMTS_NSRC_CASC 2'h3
// Write target codes
`define MMTS_WSEL_A 3'h0
`define MMTS_WSEL_B 3'h1
`define MMTS_WSEL_N1 3'h2
`define MMTS_WSEL_N2 3'h3
`define MMTS_WSEL_N3 3'h4
// Reset values and prescaler width
`define MMTS_WIDE_RST 16'hffff
`define MMTS_NARROW_RST 8'hff
`define MMTS_PRESC_W 6
`endif

// ---- hw/mmts_down_counter.v ----
`timescale 1ns/10ps
`default_nettype none
// Down counter with reload latch; underflow reloads from the latch.
module mmts_down_counter #(
   parameter W = 8
) (
   // Clock and control
   input wire mclk,
   input wire rst_n,
   input wire ce,
   // Count and reload
   input wire tick,
   input wire force_reload,
   // Write side
   input wire wr,
   input wire latch_only,
   input wire [W-1:0] wdata,
   // State
   output reg [W-1:0] count_reg,
   output reg [W-1:0] latch_reg,
   output wire underflow
);
   assign underflow = tick && (count_reg == {W{1'b0}});

   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_reg <= {W{1'b1}};
         latch_reg <= {W{1'b1}};
      end
      else if (ce)
      begin
         if (wr)
            latch_reg <= wdata;
         if (wr && !latch_only)
            count_reg <= wdata;
         else if (underflow || force_reload)
            count_reg <= (wr ? wdata : latch_reg);
         else if (tick)
            count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule // mmts_down_counter
`default_nettype wire

// ---- verification/mmts_top_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "mmts_defs.vh"
module mmts_top_sva (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Configuration
   input wire logic [1:0] mode_a,
   input wire logic [1:0] mode_b,
   input wire logic edge_select_a,
   input wire logic edge_select_b,
   input wire logic count_stop_a,
   input wire logic narrow_out_ctrl,
   input wire logic narrow_factor_sel,
   // Pins and requests
   input wire logic event_pin_a,
   input wire logic event_pin_b,
   input wire logic event_a_out_reg,
   input wire logic event_a_oe_reg,
   input wire logic wide_b_toggle_output,
   input wire logic event_b_oe_reg,
   input wire logic narrow_toggle_reg,
   input wire logic irq_a_reg,
   input wire logic irq_n1_reg,
   input wire logic irq_n2_reg,
   input wire logic irq_pin_a_reg,
   input wire logic irq_pin_b_reg
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_pulse_steady;
      (mode_a == `MMTS_MODE_PULSE) [*3];
   endsequence
   sequence s_b_no_toggle;
      (mode_b != `MMTS_BMODE_TIMER) [*3];
   endsequence
   // Edge select must settle first: the request register uses the select of the cycle before it is checked
   sequence s_sel_calm;
      ($stable(edge_select_a) && $stable(edge_select_b)) [*6];
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   irq_a_single_a: assert property (irq_a_reg |=> !irq_a_reg)
      else $error("timer A request longer than one cycle");
   pulse_oe_on_a: assert property (s_pulse_steady |-> event_a_oe_reg)
      else $error("pin A not driven in pulse mode");
   pulse_cause_a: assert property (s_pulse_steady ##0 $changed(event_a_out_reg) |-> irq_a_reg || $past(irq_a_reg))
      else $error("pin A toggled without underflow");
   pin_a_edge_a: assert property (s_sel_calm ##0 irq_pin_a_reg |-> $past(event_pin_a, 2) == !edge_select_a)
      else $error("pin A request on wrong edge");
   period_edge_a: assert property (s_sel_calm ##0 (irq_pin_b_reg && mode_b == `MMTS_BMODE_PERIOD) |-> $past(event_pin_b, 2) == edge_select_b)
      else $error("period request on wrong edge");
   hl_both_a: assert property (irq_pin_b_reg && mode_b == `MMTS_BMODE_HL |-> $past(event_pin_b, 2) != $past(event_pin_b, 6))
      else $error("width request without pin edge");
   b_oe_off_a: assert property (s_b_no_toggle |-> !event_b_oe_reg)
      else $error("pin B driven outside timer mode");
   b_out_still_a: assert property (s_b_no_toggle ##1 (mode_b != `MMTS_BMODE_TIMER) |-> $stable(wide_b_toggle_output))
      else $error("timer B toggle moved outside timer mode");
   stop_quiet_a: assert property (count_stop_a [*4] |-> !irq_a_reg)
      else $error("timer A underflow while stopped");
   narrow_cause_a: assert property ((narrow_out_ctrl && $stable(narrow_factor_sel)) [*3] ##0 $changed(narrow_toggle_reg) |-> (narrow_factor_sel ? (irq_n2_reg || $past(irq_n2_reg)) : (irq_n1_reg || $past(irq_n1_reg))))
      else $error("narrow toggle without selected underflow");
endmodule // mmts_top_sva
bind mmts_top mmts_top_sva i_mmts_top_sva (.mclk, .nrst, .mode_a, .mode_b, .edge_select_a,
   .edge_select_b, .count_stop_a, .narrow_out_ctrl, .narrow_factor_sel, .event_pin_a, .event_pin_b,
   .event_a_out_reg, .event_a_oe_reg, .wide_b_toggle_output, .event_b_oe_reg, .narrow_toggle_reg,
   .irq_a_reg, .irq_n1_reg, .irq_n2_reg, .irq_pin_a_reg, .irq_pin_b_reg);
`default_nettype wire

// ---- verification/mmts_pulse_src.sv ----
`timescale 1ns/10ps
`default_nettype none
module mmts_pulse_src (
   // Clock
   input wire logic mclk,
   // Half period in cycles; zero holds the pin at the given level
   input wire logic [7:0] half,
   input wire logic level,
   // Pin drive
   output logic pin
);
   logic [7:0] cnt_reg = 8'h00;
   initial pin = 1'b0;
   always @(posedge mclk)
   begin
      if (half == 8'h00)
      begin
         cnt_reg <= 8'h00;
         pin <= level;
      end
      else if (cnt_reg + 8'h01 >= half)
      begin
         cnt_reg <= 8'h00;
         pin <= ~pin;
      end
      else
         cnt_reg <= cnt_reg + 8'h01;
   end
endmodule // mmts_pulse_src
`default_nettype wire

// ---- verification/mmts_top_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "mmts_defs.vh"
module mmts_top_bench;
   logic mclk = 1'b0, nrst = 1'b0, ce = 1'b1, use_special_a = 1'b0, lvl_a = 1'b0;
   logic [1:0] mode_a = 2'h0, div_sel_a = 2'h0, mode_b = 2'h0, div_sel_b = 2'h0;
   logic [1:0] src_sel_n1 = 2'h0, src_sel_n2 = 2'h0, src_sel_n3 = 2'h0;
   logic edge_select_a = 1'b0, write_ctrl_a = 1'b0, count_stop_a = 1'b0, edge_select_b = 1'b0;
   logic write_ctrl_b = 1'b0, out_ctrl_b = 1'b0, narrow_write_ctrl = 1'b0, narrow_out_ctrl = 1'b0;
   logic narrow_factor_sel = 1'b0, narrow_edge = 1'b0, wr_strobe = 1'b0, rd_strobe = 1'b0;
   logic acc_high = 1'b0;
   logic [2:0] acc_sel = 3'h0;
   logic [7:0] wr_data = 8'h00, half_a = 8'h00, half_b = 8'h00, half_s = 8'h00;
   wire logic [7:0] rd_data_reg;
   wire logic event_a_out_reg, event_a_oe_reg, wide_b_toggle_output, event_b_oe_reg;
   wire logic irq_a_reg, irq_b_reg, irq_n1_reg, irq_n2_reg, irq_n3_reg, irq_pin_a_reg;
   wire logic irq_pin_b_reg, narrow_toggle_reg, src_a, src_b, special_count_source_clock;
   wire logic event_pin_a, event_pin_b;
   wire logic [6:0] irqs = {irq_pin_b_reg, irq_pin_a_reg, irq_n3_reg, irq_n2_reg, irq_n1_reg,
      irq_b_reg, irq_a_reg};
   int mismatches = 0, total_checks = 0, wn = 0;
   logic [15:0] v;
   // Pin level: device drive when enabled, the outside source otherwise
   assign event_pin_a = event_a_oe_reg ? event_a_out_reg : src_a;
   assign event_pin_b = event_b_oe_reg ? wide_b_toggle_output : src_b;
   mmts_pulse_src i_src_a (.mclk, .half(half_a), .level(lvl_a), .pin(src_a));
   mmts_pulse_src i_src_b (.mclk, .half(half_b), .level(1'b0), .pin(src_b));
   mmts_pulse_src i_src_s (.mclk, .half(half_s), .level(1'b0), .pin(special_count_source_clock));
   mmts_top i_mmts_top (.mclk, .nrst, .ce, .special_count_source_clock, .event_pin_a, .event_pin_b,
      .mode_a, .div_sel_a, .use_special_a, .edge_select_a, .write_ctrl_a, .count_stop_a, .mode_b,
      .div_sel_b, .edge_select_b, .write_ctrl_b, .out_ctrl_b, .src_sel_n1, .src_sel_n2,
      .src_sel_n3, .narrow_write_ctrl, .narrow_out_ctrl, .narrow_factor_sel, .narrow_edge,
      .wr_strobe, .rd_strobe, .acc_sel, .acc_high, .wr_data, .rd_data_reg, .event_a_out_reg,
      .event_a_oe_reg, .wide_b_toggle_output, .event_b_oe_reg, .narrow_toggle_reg, .irq_a_reg,
      .irq_b_reg, .irq_n1_reg, .irq_n2_reg, .irq_n3_reg, .irq_pin_a_reg, .irq_pin_b_reg);
   initial forever #4 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////////////
   task give_verdict;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task chk(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task wr8(input logic [2:0] s, input logic h, input logic [7:0] d);
      @(posedge mclk);
      wr_strobe <= 1'b1;
      acc_sel <= s;
      acc_high <= h;
      wr_data <= d;
      @(posedge mclk);
      wr_strobe <= 1'b0;
   endtask
   // Low byte staged first, the high byte commits both
   task wr16(input logic [2:0] s, input logic [15:0] d);
      wr8(s, 1'b0, d[7:0]);
      wr8(s, 1'b1, d[15:8]);
   endtask
   // High byte first, which freezes the low byte
   task rd16(input logic [2:0] s, output logic [15:0] d);
      @(posedge mclk);
      rd_strobe <= 1'b1;
      acc_sel <= s;
      acc_high <= 1'b1;
      @(posedge mclk);
      acc_high <= 1'b0;
      @(negedge mclk);
      d[15:8] = rd_data_reg;
      @(posedge mclk);
      rd_strobe <= 1'b0;
      @(negedge mclk);
      d[7:0] = rd_data_reg;
   endtask
   task wait_hi(input int i);
      wn = 0;
      @(negedge mclk);
      while (irqs[i] !== 1'b1 && wn < 3000)
      begin
         wn++;
         @(negedge mclk);
      end
   endtask
   // The first two intervals may straddle a reconfiguration
   task gap(input int i, input int e);
      repeat (3) wait_hi(i);
      chk(16'(wn + 1), 16'(e));
   endtask
   task count_pulses(input int i, input int n, output logic [15:0] c);
      c = 16'h0000;
      repeat (n)
      begin
         @(negedge mclk);
         c = c + {15'h0000, irqs[i]};
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      repeat (2) @(posedge mclk);
      count_stop_a <= 1'b1;
      // Start value short enough that the first underflow lands inside one wait
      wr16(3'h0, 16'h0134);
      rd16(3'h0, v);
      chk(v, 16'h0134);
      @(posedge mclk) write_ctrl_a <= 1'b1;
      wr16(3'h0, 16'h0003);
      // Clock enable low must freeze the counter although the stop bit is clear
      @(posedge mclk) ce <= 1'b0;
      count_stop_a <= 1'b0;
      repeat (100) @(posedge mclk);
      ce <= 1'b1;
      count_stop_a <= 1'b1;
      rd16(3'h0, v);
      chk(v, 16'h0134);
      for (int d = 0; d < 4; d++)
      begin
         @(posedge mclk) div_sel_a <= 2'(d);
         count_stop_a <= 1'b0;
         gap(0, 4 * (8 << d));
      end
      @(posedge mclk) use_special_a <= 1'b1;
      half_s <= 8'h05;
      gap(0, 40);
      for (int e = 0; e < 2; e++)
      begin
         @(posedge mclk) mode_a <= `MMTS_MODE_TIMER;
         edge_select_a <= 1'(e);
         @(posedge mclk) mode_a <= `MMTS_MODE_PULSE;
         // Look right after the start level lands, before any underflow can flip it
         repeat (2) @(negedge mclk);
         chk(16'(event_a_out_reg), 16'(e == 0));
         gap(0, 40);
      end
      @(posedge mclk) mode_a <= `MMTS_MODE_EVENT;
      half_a <= 8'h08;
      for (int e = 0; e < 2; e++)
      begin
         @(posedge mclk) edge_select_a <= 1'(e);
         gap(0, 64);
         wait_hi(5);
         chk(16'(event_pin_a), 16'(e == 0));
      end
      @(posedge mclk) mode_a <= `MMTS_MODE_WIDTH;
      edge_select_a <= 1'b0;
      half_a <= 8'h00;
      use_special_a <= 1'b0;
      div_sel_a <= `MMTS_DIV8;
      count_pulses(0, 200, v);
      chk(v, 16'h0000);
      @(posedge mclk) lvl_a <= 1'b1;
      gap(0, 32);
      wr16(3'h1, 16'h0003);
      for (int d = 0; d < 4; d++)
      begin
         @(posedge mclk) div_sel_b <= 2'(d);
         gap(1, 4 * (8 << d));
      end
      for (int e = 0; e < 2; e++)
      begin
         @(posedge mclk) out_ctrl_b <= 1'b0;
         edge_select_b <= 1'(e);
         @(posedge mclk) out_ctrl_b <= 1'b1;
         repeat (2) @(negedge mclk);
         chk(16'(wide_b_toggle_output), 16'(e == 0));
      end
      @(posedge mclk) out_ctrl_b <= 1'b0;
      wr16(3'h1, 16'h8080);
      @(posedge mclk) write_ctrl_b <= 1'b1;
      wr16(3'h1, 16'h0010);
      rd16(3'h1, v);
      chk(v[15:8], 16'h0080);
      @(posedge mclk) write_ctrl_b <= 1'b0;
      div_sel_b <= `MMTS_DIV8;
      mode_b <= `MMTS_BMODE_PERIOD;
      half_b <= 8'h28;
      wr16(3'h1, 16'h1000);
      for (int e = 0; e < 2; e++)
      begin
         @(posedge mclk) edge_select_b <= 1'(e);
         repeat (2) wait_hi(6);
         chk(16'(event_pin_b), 16'(e));
      end
      repeat (40) @(posedge mclk);
      rd16(3'h1, v);
      chk(v[15:3], 16'h01fe);
      @(posedge mclk) mode_b <= `MMTS_BMODE_HL;
      for (int e = 0; e < 2; e++)
      begin
         @(posedge mclk) edge_select_b <= 1'(e);
         count_pulses(6, 160, v);
         chk(v, 16'h0004);
      end
      @(posedge mclk) mode_b <= `MMTS_BMODE_EVENT;
      edge_select_b <= 1'b0;
      half_b <= 8'h04;
      wr16(3'h1, 16'h0001);
      gap(1, 16);
      @(posedge mclk) src_sel_n1 <= `MMTS_NSRC_DIV16;
      src_sel_n2 <= `MMTS_NSRC_CASC;
      wr8(3'h2, 1'b0, 8'h03);
      wr8(3'h3, 1'b0, 8'h01);
      gap(2, 64);
      gap(3, 128);
      @(posedge mclk) narrow_factor_sel <= 1'b1;
      narrow_edge <= 1'b1;
      narrow_out_ctrl <= 1'b1;
      repeat (2) @(negedge mclk);
      chk(16'(narrow_toggle_reg), 16'h0000);
      wait_hi(3);
      repeat (3) @(negedge mclk);
      chk(16'(narrow_toggle_reg), 16'h0001);
      @(posedge mclk) narrow_write_ctrl <= 1'b1;
      wr8(3'h2, 1'b0, 8'h07);
      rd16(3'h2, v);
      chk(v[7:2], 16'h0000);
      gap(2, 128);
      for (int k = 0; k < 4; k++)
      begin
         @(posedge mclk) src_sel_n3 <= 2'(k);
         wr8(3'h2, 1'b0, 8'h07);
         wr8(3'h3, 1'b0, 8'h01);
         wr8(3'h4, 1'b0, 8'h00);
         gap(4, k == 0 ? 8 : k == 1 ? 16 : k == 2 ? 10 : 256);
      end
      give_verdict;
   end
   initial
   begin
      #320000;
      mismatches++;
      give_verdict;
   end
endmodule // mmts_top_bench
`default_nettype wire
